// File: acrb_defines.svh
`ifndef ACRB_DEFINES_SVH
`define ACRB_DEFINES_SVH

// 48-bit register block base, upper 16 bits carry bus and node
`define ACRB_BASE 48'hffff_f1f0_0000
`define ACRB_OFS_MAX_SIZE 12'h000
`define ACRB_OFS_STEP 12'h004
`define ACRB_OFS_ORIGIN 12'h008
`define ACRB_OFS_EXTENT 12'h00c
`define ACRB_OFS_CODING 12'h010
`define ACRB_OFS_SUPPORT 12'h014

// msb-first numbering: bits 0-15 are [31:16], bits 16-31 are [15:0]
`define ACRB_HI_MSB 31
`define ACRB_HI_LSB 16
`define ACRB_LO_MSB 15
`define ACRB_LO_LSB 0
// coding field, bits 0-7 in msb-first numbering
`define ACRB_CODE_MSB 31
`define ACRB_CODE_LSB 24
`define ACRB_SUPPORT_BITS 11

`define ACRB_MONO_HMAX 16'h0570
`define ACRB_MONO_VMAX 16'h0410
`define ACRB_COLOR_HMAX 16'h056c
`define ACRB_COLOR_VMAX 16'h040e
`define ACRB_MONO_STEP 16'h0001
`define ACRB_COLOR_STEP 16'h0002
`define ACRB_ORIGIN_RST 16'h0000

`define ACRB_CODE_MONO8 8'h00
`define ACRB_CODE_YUV422 8'h02
`define ACRB_CODE_MONO16 8'h05
`define ACRB_CODE_RAW8 8'h09
`define ACRB_CODE_RAW16 8'h0a
// support masks in identifier order, identifier n at msb-first bit n
`define ACRB_MONO_SUPPORT 11'b100001_00000
`define ACRB_COLOR_SUPPORT 11'b101000_00011

`endif

// File: acrb_pkg.sv
package acrb_pkg;
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } acrb_pair_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [47:0] addr;
    logic [31:0] wdata;
  } acrb_req_t;

  typedef struct packed {
    logic        ack;
    logic        hit;
    logic [31:0] rdata;
  } acrb_rsp_t;

  typedef struct packed {
    logic raw;
    logic wide;
    logic color;
  } acrb_fmt_t;
endpackage

// File: acrb_regs.sv
`include "acrb_defines.svh"

// Operation
// - bank at fixed base plus byte offset
// - bit 0 is the word msb
// - max size query per variant
// - size step query per variant
// - origin register, resets to zero
// - extent register, resets to max size
// - coding select, high byte, variant default
// - support flags, one per identifier
// - variant support sets fixed
// - codes 9,10 raw; 5 mono16
module acrb_regs
  import acrb_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic color_variant, // static strap: 1 = colour variant
  input wire acrb_req_t bus_req, // register request from link layer
  output acrb_rsp_t bus_rsp_q, // one-cycle answer to request
  output acrb_pair_t origin_q, // window left column / top row
  output acrb_pair_t extent_q, // window width / height
  output logic [7:0] coding_q, // selected pixel coding
  output acrb_fmt_t fmt_q // decoded format of the coding
);

  logic variant_q;
  logic variant_d;
  logic loaded_q;
  logic loaded_d;
  // next values of the writable words and the answer
  acrb_pair_t origin_d;
  acrb_pair_t extent_d;
  logic [7:0] coding_d;
  acrb_rsp_t rsp_d;
  acrb_fmt_t fmt_d;
  acrb_pair_t max_size;
  acrb_pair_t step;
  logic [10:0] support_ord;
  logic [31:0] support_word;
  logic [31:0] coding_word;
  logic [31:0] rdata_mux;
  // request decode
  logic in_bank;
  logic [11:0] ofs;
  logic base_hit;
  logic word_hit;
  logic aligned;
  acrb_pair_t wdata_pair;
  logic take;
  logic take_wr;
  logic sel_max;
  logic sel_step;
  logic sel_origin;
  logic sel_extent;
  logic sel_coding;
  logic sel_support;
  logic sel_any;
  logic wr_origin;
  logic wr_extent;
  logic wr_coding;

  // strap is captured once after reset release, never during it
  always_comb begin
    loaded_d = 1'b1;
    variant_d = loaded_q ? variant_q : color_variant;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      loaded_q <= 1'b0;
      variant_q <= 1'b0;
    end else begin
      loaded_q <= loaded_d;
      variant_q <= variant_d;
    end
  end

  // inquiry contents depend only on the captured strap
  always_comb begin
    if (variant_q) begin
      max_size.hi = `ACRB_COLOR_HMAX;
      max_size.lo = `ACRB_COLOR_VMAX;
    end else begin
      max_size.hi = `ACRB_MONO_HMAX;
      max_size.lo = `ACRB_MONO_VMAX;
    end
  end

  always_comb begin
    if (variant_q) begin
      step.hi = `ACRB_COLOR_STEP;
      step.lo = `ACRB_COLOR_STEP;
    end else begin
      step.hi = `ACRB_MONO_STEP;
      step.lo = `ACRB_MONO_STEP;
    end
  end

  always_comb begin
    if (variant_q) begin
      support_ord = `ACRB_COLOR_SUPPORT;
    end else begin
      support_ord = `ACRB_MONO_SUPPORT;
    end
  end

  // identifier n lands on msb-first bit n, i.e. word bit 31-n
  generate
    for (genvar n = 0; n < 32; n++) begin : g_sup
      if (n < `ACRB_SUPPORT_BITS) begin : g_flag
        assign support_word[31-n] = support_ord[10-n];
      end else begin : g_rsvd
        assign support_word[31-n] = 1'b0;
      end
    end
  endgenerate

  // only bits 0-7 carry the coding; bits 8-31 read as zero
  generate
    for (genvar n = 0; n < 32; n++) begin : g_code
      if (n >= `ACRB_CODE_LSB) begin : g_field
        assign coding_word[n] = coding_q[n-`ACRB_CODE_LSB];
      end else begin : g_rsvd
        assign coding_word[n] = 1'b0;
      end
    end
  endgenerate

  // upper 36 address bits must match base; bus and node ids are part of it
  assign base_hit = bus_req.addr[47:12] == 36'(`ACRB_BASE >> 12);
  // the bank spans 32 bytes, of which six words are mapped
  assign word_hit = bus_req.addr[11:5] == 7'h00;
  // quadlet access only; byte lanes inside a word are not decoded
  assign aligned = bus_req.addr[1:0] == 2'b00;
  assign in_bank = base_hit && word_hit && aligned;
  assign ofs = bus_req.addr[11:0];
  assign wdata_pair = bus_req.wdata;
  // a request in the strap capture cycle is dropped, not queued
  assign take = loaded_q && bus_req.req;
  assign take_wr = take && bus_req.wr;

  // one select per mapped word; a hole or misaligned address raises none
  always_comb begin
    sel_max = 1'b0;
    sel_step = 1'b0;
    sel_origin = 1'b0;
    sel_extent = 1'b0;
    sel_coding = 1'b0;
    sel_support = 1'b0;
    if (in_bank) begin
      case (ofs)
        `ACRB_OFS_MAX_SIZE: sel_max = 1'b1;
        `ACRB_OFS_STEP: sel_step = 1'b1;
        `ACRB_OFS_ORIGIN: sel_origin = 1'b1;
        `ACRB_OFS_EXTENT: sel_extent = 1'b1;
        `ACRB_OFS_CODING: sel_coding = 1'b1;
        `ACRB_OFS_SUPPORT: sel_support = 1'b1;
        default: sel_max = 1'b0;
      endcase
    end
  end

  // hit means a mapped word, for reads and writes alike
  assign sel_any = sel_max || sel_step || sel_origin || sel_extent
    || sel_coding || sel_support;

  // inquiry words get no write strobe, so writes to them fall away
  assign wr_origin = take_wr && sel_origin;
  assign wr_extent = take_wr && sel_extent;
  assign wr_coding = take_wr && sel_coding;

  // left column in the upper half, top row in the lower
  always_comb begin
    origin_d = origin_q;
    if (wr_origin) begin
      origin_d.hi = wdata_pair.hi;
      origin_d.lo = wdata_pair.lo;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      origin_q.hi <= `ACRB_ORIGIN_RST;
      origin_q.lo <= `ACRB_ORIGIN_RST;
    end else begin
      origin_q <= origin_d;
    end
  end

  always_comb begin
    extent_d = extent_q;
    // until the strap is caught the defaults track the variant
    if (!loaded_q) begin
      extent_d.hi = variant_d ? `ACRB_COLOR_HMAX : `ACRB_MONO_HMAX;
      extent_d.lo = variant_d ? `ACRB_COLOR_VMAX : `ACRB_MONO_VMAX;
    end else if (wr_extent) begin
      // no step check: keeping multiples is the host's duty
      extent_d.hi = wdata_pair.hi;
      extent_d.lo = wdata_pair.lo;
    end
  end

  // reset holds the mono default; the colour one lands at strap capture
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      extent_q.hi <= `ACRB_MONO_HMAX;
      extent_q.lo <= `ACRB_MONO_VMAX;
    end else begin
      extent_q <= extent_d;
    end
  end

  // until the strap is caught the default tracks the variant
  always_comb begin
    coding_d = coding_q;
    if (!loaded_q) begin
      coding_d = variant_d ? `ACRB_CODE_YUV422 : `ACRB_CODE_MONO8;
    end else if (wr_coding) begin
      // reserved bits 8-31 of the write are dropped here
      coding_d = bus_req.wdata[`ACRB_CODE_MSB:`ACRB_CODE_LSB];
    end
  end

  // same trade as the extent: mono at reset, variant one edge later
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      coding_q <= `ACRB_CODE_MONO8;
    end else begin
      coding_q <= coding_d;
    end
  end

  // read mux; a write answers with the value held before it
  always_comb begin
    rdata_mux = 32'h00000000;
    if (sel_max) begin
      rdata_mux = max_size;
    end else if (sel_step) begin
      rdata_mux = step;
    end else if (sel_origin) begin
      rdata_mux = origin_q;
    end else if (sel_extent) begin
      rdata_mux = extent_q;
    end else if (sel_coding) begin
      rdata_mux = coding_word;
    end else if (sel_support) begin
      rdata_mux = support_word;
    end
  end

  // data is zero whenever ack is low, so a stale word never leaks out
  always_comb begin
    rsp_d = '0;
    if (take) begin
      rsp_d.ack = 1'b1;
      rsp_d.hit = sel_any;
      rsp_d.rdata = rdata_mux;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_rsp_q.ack <= 1'b0;
      bus_rsp_q.hit <= 1'b0;
      bus_rsp_q.rdata <= 32'h00000000;
    end else begin
      bus_rsp_q <= rsp_d;
    end
  end

  // format decode; unsupported codes are not filtered, host must avoid
  always_comb begin
    fmt_d = '0;
    fmt_d.color = variant_d;
    case (coding_d)
      `ACRB_CODE_RAW8: fmt_d.raw = 1'b1;
      `ACRB_CODE_RAW16: begin
        fmt_d.raw = 1'b1;
        fmt_d.wide = 1'b1;
      end
      `ACRB_CODE_MONO16: fmt_d.wide = 1'b1;
      default: fmt_d.wide = 1'b0;
    endcase
  end

  // colour flag follows the strap from the capture edge on
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fmt_q.raw <= 1'b0;
      fmt_q.wide <= 1'b0;
      fmt_q.color <= 1'b0;
    end else begin
      fmt_q <= fmt_d;
    end
  end

endmodule

// File: acrb_regs_checker.sv
`include "acrb_defines.svh"
module acrb_regs_checker
  import acrb_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst_b, // reset
  input wire logic color_variant, // strap
  input wire acrb_req_t bus_req, // request
  input wire acrb_rsp_t bus_rsp_q, // answer
  input wire acrb_pair_t origin_q, // origin
  input wire acrb_fmt_t fmt_q, // format
  input wire acrb_pair_t extent_q, // extent
  input wire logic [7:0] coding_q // coding
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  logic rd;
  logic c;
  logic [47:0] ofs;
  // base has a zero low part, so xor leaves the offset
  assign ofs = bus_req.addr ^ `ACRB_BASE;
  assign rd = bus_req.req && !bus_req.wr;
  assign c = color_variant;
  a_ack_follows: assert property (bus_req.req |=> bus_rsp_q.ack)
    else $error("ack missing");
  a_ack_drops: assert property (!bus_req.req |=> !bus_rsp_q.ack)
    else $error("ack stuck");
  a_miss_zero: assert property (bus_rsp_q.ack && !bus_rsp_q.hit
    |-> bus_rsp_q.rdata == 32'h0) else $error("miss data");
  a_max_read: assert property (rd && ofs == 48'h0 |=> bus_rsp_q.rdata
    == (c ? 32'h056c040e : 32'h05700410)) else $error("max size");
  a_step_read: assert property (rd && ofs == 48'h4 |=> bus_rsp_q.rdata
    == (c ? 32'h00020002 : 32'h00010001)) else $error("step");
  a_support_read: assert property (rd && ofs == 48'h14
    |=> bus_rsp_q.rdata == (c ? 32'ha0600000 : 32'h84000000))
    else $error("support");
  a_origin_write: assert property (bus_req.req && bus_req.wr
    && ofs == 48'h8 |=> origin_q == $past(bus_req.wdata))
    else $error("origin");
  a_raw_format: assert property (fmt_q.raw
    == (coding_q == 8'h09 || coding_q == 8'h0a)) else $error("raw");
  a_wide_format: assert property (fmt_q.wide
    == (coding_q == 8'h05 || coding_q == 8'h0a)) else $error("wide");
  a_extent_write: assert property (bus_req.req && bus_req.wr
    && ofs == 48'hc |=> extent_q == $past(bus_req.wdata))
    else $error("extent");
endmodule
bind acrb_regs acrb_regs_checker chk_i (.core_clk(core_clk), .rst_b(rst_b),
  .color_variant(color_variant), .bus_req(bus_req), .bus_rsp_q(bus_rsp_q),
  .origin_q(origin_q), .fmt_q(fmt_q), .extent_q(extent_q),
  .coding_q(coding_q));

// File: acrb_host.sv
`include "acrb_defines.svh"
module acrb_host
  import acrb_pkg::*;
(
  input wire logic core_clk, // clock
  output acrb_req_t bus_req, // request
  input wire acrb_rsp_t bus_rsp_q // answer
);
  timeunit 1ns;
  timeprecision 100ps;
  initial bus_req = '0;
  task automatic xfer(input logic wr, input logic [11:0] ofs,
    input logic [31:0] wd, output acrb_rsp_t rsp);
    @(negedge core_clk);
    bus_req = '{1'b1, wr, `ACRB_BASE + 48'(ofs), wd};
    @(negedge core_clk);
    rsp = bus_rsp_q;
    // idle fields flip so a stale value is never mistaken for live
    bus_req = '{1'b0, ~wr, ~bus_req.addr, ~wd};
  endtask
endmodule

// File: acrb_regs_tb_top.sv
module acrb_regs_tb_top
  import acrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic color_variant = 1'b0;
  acrb_req_t bus_req;
  acrb_rsp_t bus_rsp_q;
  acrb_rsp_t r;
  acrb_pair_t origin_q;
  acrb_pair_t extent_q;
  logic [7:0] coding_q;
  acrb_fmt_t fmt_q;
  int mismatches = 0;
  int num_checks = 0;
  always #12.5 core_clk = ~core_clk;
  acrb_regs acrb_regs_i (.core_clk(core_clk), .rst_b(rst_b),
    .color_variant(color_variant), .bus_req(bus_req), .bus_rsp_q(bus_rsp_q),
    .origin_q(origin_q), .extent_q(extent_q), .coding_q(coding_q),
    .fmt_q(fmt_q));
  acrb_host acrb_host_i (.core_clk(core_clk), .bus_req(bus_req),
    .bus_rsp_q(bus_rsp_q));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    acrb_host_i.xfer(1'b0, a, 32'h0, r);
    cmp("rdata", e, r.rdata);
    cmp("hit", 32'(a < 12'h018), 32'(r.hit));
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acrb_host_i.xfer(1'b1, a, d, r);
    cmp("ack", 32'h1, 32'(r.ack));
  endtask
  task automatic t_defaults(input logic c);
    rd(12'h000, c ? 32'h056c040e : 32'h05700410);
    rd(12'h004, c ? 32'h00020002 : 32'h00010001);
    rd(12'h008, 32'h0);
    rd(12'h00c, c ? 32'h056c040e : 32'h05700410);
    rd(12'h010, c ? 32'h02000000 : 32'h0);
    rd(12'h014, c ? 32'ha0600000 : 32'h84000000);
    rd(12'h018, 32'h0);
  endtask
  task automatic t_writes(input logic c);
    logic [7:0] codes[4] = '{8'h05, 8'h09, 8'h0a, 8'h00};
    wr(12'h008, 32'h00100020);
    cmp("origin", 32'h00100020, origin_q);
    wr(12'h00c, 32'h00400030);
    cmp("extent", 32'h00400030, extent_q);
    wr(12'h000, 32'hffffffff);
    rd(12'h000, c ? 32'h056c040e : 32'h05700410);
    wr(12'h004, 32'hffffffff);
    rd(12'h004, c ? 32'h00020002 : 32'h00010001);
    wr(12'h014, 32'hffffffff);
    rd(12'h014, c ? 32'ha0600000 : 32'h84000000);
    // only codings the variant supports are written
    foreach (codes[i]) if (c ? codes[i] != 8'h05 : !codes[i][3]) begin
      wr(12'h010, {codes[i], 24'hffffff});
      rd(12'h010, {codes[i], 24'h0});
      cmp("coding", {24'h0, codes[i]}, 32'(coding_q));
      cmp("fmt", {29'h0, codes[i] == 8'h09 || codes[i] == 8'h0a,
        codes[i] == 8'h05 || codes[i] == 8'h0a, c}, 32'(fmt_q));
    end
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    for (int c = 0; c < 2; c++) begin
      rst_b = 1'b0;
      color_variant = c[0];
      repeat (4) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (2) @(negedge core_clk);
      t_defaults(c[0]);
      t_writes(c[0]);
    end
    wrap_up();
  end
  initial begin
    #100us;
    mismatches++;
    wrap_up();
  end
endmodule
